/* File: usfs_top.sv */
// unsolicited frame sender: Avalon-MM registers, source buffer, frame builder
// assumes charReady, portIdle and replyBusy come from logic on ref_clk
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "usfs_cfg.svh"
module usfs_top #(
  parameter int BUF_AW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave, word addressed
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // character stream towards ports and link units
  output logic [7:0] charData_q,
  output logic charValid_q,
  output usfs_pkg::usfs_dest_t charDest_q,
  input wire logic [3:0] charReady,
  // serial port line state and command reply traffic
  input wire logic [1:0] portIdle,
  input wire logic [1:0] replyBusy,
  // port control
  output logic [3:0] portReset_q,
  output logic [1:0] unsolPending_q,
  output logic [3:0] txReadyFlag_q
);
  import usfs_pkg::*;

  // bus side state
  logic waitReq_q;
  logic [31:0] readData_q;
  logic [15:0] mainNode_q;
  logic [15:0] periNode_q;
  logic [1:0] cmdLinkMode_q;
  logic [15:0] sendAddr_q;
  logic [15:0] sendCtrl_q;
  logic [3:0] resetBits_q;
  logic rejectSeen_q;

  // frame builder state
  usfs_state_t state_q;
  usfs_dest_t dest_q;
  logic [7:0] pos_q;
  logic [7:0] dataEnd_q;
  logic [7:0] lastPos_q;
  logic [BUF_AW-1:0] start_q;
  logic [7:0] fcs_q;
  logic [7:0] node_q;

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = readData_q;

  // decoded bus events
  logic wrFire;
  logic inBuf;
  logic [15:0] wdata;
  assign wrFire = avs_write & ~waitReq_q & (avs_byteenable[1:0] == 2'h3);
  assign inBuf = (avs_address[`USFS_BUF_HI_MSB:`USFS_BUF_HI_LSB] == 6'h00);
  assign wdata = avs_writedata[15:0];

  function automatic logic bcdOk8(input logic [7:0] v);
    bcdOk8 = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction

  function automatic logic [6:0] bcdBin8(input logic [7:0] v);
    bcdBin8 = 7'({3'h0, v[7:4]} * 7'h0A + {3'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'hA) ? (`USFS_CH_ZERO + {4'h0, n}) : (`USFS_CH_ALPHA + {4'h0, n});
  endfunction

  logic nodeOk;
  assign nodeOk = (wdata[15:8] == 8'h00) && bcdOk8(wdata[7:0])
                  && (bcdBin8(wdata[7:0]) <= `USFS_NODE_MAX); // RULE1

  // one access takes two cycles: waitrequest drops for the second
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waitReq_q <= 1'b1;
    end else if ((avs_read | avs_write) & waitReq_q) begin
      waitReq_q <= 1'b0;
    end else begin
      waitReq_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readData_q <= 32'h0000_0000;
    end else if (avs_read & waitReq_q) begin
      case (avs_address)
        `USFS_REG_MAIN_NODE: readData_q <= {16'h0000, mainNode_q};
        `USFS_REG_PERI_NODE: readData_q <= {16'h0000, periNode_q};
        `USFS_REG_MODE: readData_q <= {30'h0, cmdLinkMode_q};
        `USFS_REG_SEND_ADDR: readData_q <= {16'h0000, sendAddr_q};
        `USFS_REG_SEND_CTRL: readData_q <= {16'h0000, sendCtrl_q};
        `USFS_REG_STATUS: readData_q <= {26'h0, rejectSeen_q, (state_q != ST_IDLE),
                                          txReadyFlag_q};
        `USFS_REG_PORT_RESET: readData_q <= {28'h0, resetBits_q};
        default: readData_q <= 32'h0000_0000;
      endcase
    end
  end

  // node words, one per serial port; bad values leave the old one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mainNode_q <= `USFS_NODE_RESET; // RULE2
      periNode_q <= `USFS_NODE_RESET; // RULE2
    end else if (wrFire && nodeOk) begin
      if (avs_address == `USFS_REG_MAIN_NODE) begin
        mainNode_q <= wdata; // RULE4
      end
      if (avs_address == `USFS_REG_PERI_NODE) begin
        periNode_q <= wdata; // RULE4
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmdLinkMode_q <= `USFS_MODE_RESET;
      sendAddr_q <= 16'h0000;
      sendCtrl_q <= 16'h0000;
    end else if (wrFire) begin
      if (avs_address == `USFS_REG_MODE) begin
        cmdLinkMode_q <= wdata[1:0];
      end
      if (avs_address == `USFS_REG_SEND_ADDR) begin
        sendAddr_q <= wdata;
      end
      if (avs_address == `USFS_REG_SEND_CTRL) begin
        sendCtrl_q <= wdata;
      end
    end
  end

  // launch check on a write of the count word
  logic launchWr;
  logic cntOk;
  logic ctrlOk;
  logic modeOk;
  logic accept;
  logic [6:0] cntBin;
  usfs_dest_t reqDest;
  assign launchWr = wrFire && (avs_address == `USFS_REG_SEND_COUNT);
  assign cntBin = bcdBin8(wdata[7:0]);
  assign cntOk = (wdata[15:8] == 8'h00) && bcdOk8(wdata[7:0])
                 && (cntBin <= `USFS_COUNT_MAX); // RULE8 RULE20
  assign reqDest = usfs_dest_t'(sendCtrl_q[`USFS_CTRL_DEST_MSB:`USFS_CTRL_DEST_LSB]);
  assign ctrlOk = (sendCtrl_q[15:14] == 2'h0) && (sendCtrl_q[11:0] == 12'h000); // RULE7
  assign modeOk = reqDest[1] | cmdLinkMode_q[reqDest[0]]; // RULE3
  // requester is expected to poll the flag first; a launch without it is refused
  assign accept = launchWr && cntOk && ctrlOk && modeOk && (state_q == ST_IDLE)
                  && txReadyFlag_q[reqDest] && !resetBits_q[reqDest]; // RULE5 RULE6

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rejectSeen_q <= 1'b0;
    end else if (launchWr) begin
      rejectSeen_q <= !accept; // RULE20
    end
  end

  // self-clearing reset bits; a new write in the same cycle is kept
  logic [3:0] rstWr;
  assign rstWr = (wrFire && (avs_address == `USFS_REG_PORT_RESET)) ? wdata[3:0] : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      resetBits_q <= 4'h0;
      portReset_q <= 4'h0;
    end else begin
      resetBits_q <= rstWr; // RULE14
      portReset_q <= resetBits_q; // RULE14 RULE15
    end
  end

  logic abortActive;
  assign abortActive = resetBits_q[dest_q] && (state_q != ST_IDLE);

  // source buffer
  logic [15:0] memData;
  logic [7:0] dataIdx;
  logic [7:0] fetchIdx;
  logic [BUF_AW-1:0] rdAddr;
  assign dataIdx = pos_q - `USFS_HDR_LEN;
  // fetch one position ahead: registered read must hold the word by PREP
  assign fetchIdx = pos_q + 8'h01 - `USFS_HDR_LEN;
  assign rdAddr = start_q + BUF_AW'(fetchIdx[7:2]);

  usfs_data_mem #(
    .AW(BUF_AW),
    .DW(16)
  ) u_mem (
    .ref_clk(ref_clk),
    .wrEn(wrFire && inBuf),
    .wrAddr(avs_address[BUF_AW-1:0]),
    .wrData(wdata),
    .rdAddr(rdAddr),
    .rdData_q(memData)
  );

  // character at the current frame position
  logic [3:0] nib;
  logic [7:0] nextChar;
  always_comb begin
    case (dataIdx[1:0])
      2'h0: nib = memData[15:12];
      2'h1: nib = memData[11:8];
      2'h2: nib = memData[7:4];
      default: nib = memData[3:0];
    endcase
    if (pos_q == 8'h00) begin
      nextChar = `USFS_CH_AT; // RULE18
    end else if (pos_q == 8'h01) begin
      nextChar = hexChar(node_q[7:4]); // RULE18
    end else if (pos_q == 8'h02) begin
      nextChar = hexChar(node_q[3:0]);
    end else if (pos_q == 8'h03) begin
      nextChar = `USFS_CH_E; // RULE13
    end else if (pos_q == 8'h04) begin
      nextChar = `USFS_CH_X;
    end else if (pos_q < dataEnd_q) begin
      nextChar = hexChar(nib); // RULE13
    end else if (pos_q == dataEnd_q) begin
      nextChar = hexChar(fcs_q[7:4]); // RULE19
    end else if (pos_q == dataEnd_q + 8'h01) begin
      nextChar = hexChar(fcs_q[3:0]);
    end else if (pos_q == dataEnd_q + 8'h02) begin
      nextChar = `USFS_CH_STAR; // RULE18
    end else begin
      nextChar = `USFS_CH_CR;
    end
  end

  logic charTaken;
  assign charTaken = charValid_q && charReady[dest_q];

  // frame sequencer; one character in flight, no reply is ever awaited
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      dest_q <= DEST_MAIN;
      pos_q <= 8'h00;
      dataEnd_q <= `USFS_HDR_LEN;
      lastPos_q <= 8'h00;
      start_q <= '0;
      node_q <= 8'h00;
    end else if (abortActive) begin
      state_q <= ST_IDLE; // RULE14 RULE15
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_WAIT;
            dest_q <= reqDest;
            pos_q <= 8'h00;
            start_q <= sendAddr_q[BUF_AW-1:0];
            dataEnd_q <= `USFS_HDR_LEN + {cntBin, 1'b0};
            lastPos_q <= `USFS_HDR_LEN + {cntBin, 1'b0} + 8'h03;
            // link units keep their own node numbering
            node_q <= (reqDest == DEST_MAIN) ? mainNode_q[7:0] :
                      (reqDest == DEST_PERI) ? periNode_q[7:0] : 8'h00;
          end
        end
        ST_WAIT: begin
          if (dest_q[1] || !replyBusy[dest_q[0]]) begin
            state_q <= ST_PREP; // RULE16
          end
        end
        ST_PREP: begin
          state_q <= ST_EMIT;
        end
        ST_EMIT: begin
          if (charTaken) begin
            pos_q <= pos_q + 8'h01;
            if (pos_q != lastPos_q) begin
              state_q <= ST_PREP;
            end else if (dest_q[1]) begin
              state_q <= ST_IDLE; // RULE11
            end else begin
              state_q <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          if (portIdle[dest_q[0]]) begin
            state_q <= ST_IDLE; // RULE10
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // character register and check code
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      charValid_q <= 1'b0;
      charData_q <= 8'h00;
      charDest_q <= DEST_MAIN;
    end else if (abortActive) begin
      charValid_q <= 1'b0;
    end else if (state_q == ST_PREP) begin
      charValid_q <= 1'b1;
      charData_q <= nextChar;
      charDest_q <= dest_q;
    end else if (charTaken) begin
      charValid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fcs_q <= 8'h00;
    end else if (accept) begin
      fcs_q <= 8'h00;
    end else if (charTaken && (pos_q < dataEnd_q)) begin
      fcs_q <= fcs_q ^ charData_q; // RULE19
    end
  end

  // ready flags: cleared on acceptance, set on completion or on reset
  logic [3:0] flagSet;
  always_comb begin
    flagSet = resetBits_q;
    if (state_q == ST_EMIT && charTaken && pos_q == lastPos_q && dest_q[1]) begin
      flagSet[dest_q] = 1'b1; // RULE11
    end
    if (state_q == ST_DRAIN && portIdle[dest_q[0]]) begin
      flagSet[dest_q] = 1'b1; // RULE10
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txReadyFlag_q <= `USFS_READY_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (flagSet[i]) begin
          txReadyFlag_q[i] <= 1'b1;
        end else if (accept && (reqDest == usfs_dest_t'(i))) begin
          txReadyFlag_q[i] <= 1'b0; // RULE9
        end
      end
    end
  end

  // hold other serial traffic while a frame is pending or going out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unsolPending_q <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        unsolPending_q[p] <= (state_q != ST_IDLE) && !dest_q[1]
                             && (dest_q[0] == p[0]) && !abortActive; // RULE17
      end
    end
  end
endmodule // usfs_top
`default_nettype wire

/* File: usfs_cfg.svh */
// constants for the unsolicited serial frame sender: offsets, fields, reset values
// assumes inclusion by bare name from the top module, the assertions and the bench
// Overview of operation
// RULE1: node number is two BCD digits, only 00 through 31 accepted
// RULE2: node number resets to 00
// RULE3: node number and unsolicited sends on a port need command-link mode; only sends check the mode here, node words take writes in any mode
// RULE4: main and peripheral ports each have their own node number word
// RULE5: requester checks main or peripheral ready flag before a send
// RULE6: requester checks the link unit ready flag before sending through a unit
// RULE7: request carries source start word address and destination control code
// RULE8: byte count is four BCD digits, 0000 through 0061
// RULE9: destination ready flag stays cleared from acceptance until transmission finishes
// RULE10: serial ports get their ready flag back after the last character left
// RULE11: link units get their ready flag back once the data is handed over
// RULE12: no reply expected; host builds its own acknowledgement if needed
// RULE13: frame order: EX header, up to 122 data chars, check code, terminator
// RULE14: port reset bits restore initial state and clear themselves
// RULE15: each link unit has its own reset bit restoring its initial state
// RULE16: a command reply in progress finishes before the unsolicited frame starts
// RULE17: otherwise a pending unsolicited frame beats other traffic on that port
// RULE18: frame opens with at-sign and node digits, ends asterisk then CR
// RULE19: check code is XOR from at-sign to last data char, two hex chars
// RULE20: bad BCD or too large count is refused and ready flag stays set
`ifndef USFS_CFG_SVH
`define USFS_CFG_SVH

// register word indices; byte address is four times the index
`define USFS_REG_MAIN_NODE 14'h19F8
`define USFS_REG_PERI_NODE 14'h19FD
`define USFS_REG_MODE 14'h1A00
`define USFS_REG_SEND_ADDR 14'h1A01
`define USFS_REG_SEND_CTRL 14'h1A02
`define USFS_REG_SEND_COUNT 14'h1A03
`define USFS_REG_STATUS 14'h1A04
`define USFS_REG_PORT_RESET 14'h1A05
// buffer words occupy indices whose upper bits are zero
`define USFS_BUF_HI_MSB 13
`define USFS_BUF_HI_LSB 8

// reset values
`define USFS_NODE_RESET 16'h0000
`define USFS_MODE_RESET 2'h3
`define USFS_READY_RESET 4'hF

// field positions of the control code
`define USFS_CTRL_DEST_LSB 12
`define USFS_CTRL_DEST_MSB 13

// limits
`define USFS_NODE_MAX 7'h1F
`define USFS_COUNT_MAX 7'h3D
`define USFS_HDR_LEN 8'h05

// frame characters
`define USFS_CH_AT 8'h40
`define USFS_CH_E 8'h45
`define USFS_CH_X 8'h58
`define USFS_CH_STAR 8'h2A
`define USFS_CH_CR 8'h0D
`define USFS_CH_ZERO 8'h30
`define USFS_CH_ALPHA 8'h37

`endif

/* File: usfs_pkg.sv */
// types shared by the unsolicited serial frame sender
// uses no include file; usfs_cfg.svh is not needed here
package usfs_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_PREP = 5'b00100,
    ST_EMIT = 5'b01000,
    ST_DRAIN = 5'b10000
  } usfs_state_t;

  typedef enum logic [1:0] {
    DEST_MAIN = 2'h0,
    DEST_PERI = 2'h1,
    DEST_UNIT0 = 2'h2,
    DEST_UNIT1 = 2'h3
  } usfs_dest_t;
endpackage

/* File: usfs_data_mem.sv */
// transmit source buffer: one write port, one read port with registered data
// assumes a single clock shared by both ports
`timescale 1ns/1ps
`default_nettype none
module usfs_data_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // read port
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdData_q <= mem[rdAddr];
  end
endmodule // usfs_data_mem
`default_nettype wire

/* File: usfs_props.sv */
// assertions on the ports of usfs_top
// assumes one clock and a synchronous active-high reset; bound below
`timescale 1ns/1ps
`default_nettype none
`include "usfs_cfg.svh"
module usfs_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register bus
  input wire logic [13:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // character stream
  input wire logic [7:0] charData_q,
  input wire logic charValid_q,
  input wire usfs_pkg::usfs_dest_t charDest_q,
  input wire logic [3:0] charReady,
  input wire logic [1:0] portIdle,
  input wire logic [1:0] replyBusy,
  // port control
  input wire logic [3:0] portReset_q,
  input wire logic [1:0] unsolPending_q,
  input wire logic [3:0] txReadyFlag_q
);
  import usfs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // terminator is the only carriage return in a frame
  sequence sCrTake;
    charValid_q && charReady[charDest_q] && charData_q == `USFS_CH_CR;
  endsequence
  sequence sCrMain;
    sCrTake ##0 charDest_q == DEST_MAIN;
  endsequence
  chk_launch_at: assert property ($fell(txReadyFlag_q[0]) && !replyBusy[0] |-> ##2 charValid_q
    && charData_q == `USFS_CH_AT && charDest_q == DEST_MAIN)
    else $error("frame start missing");
  chk_reply_first: assert property ($fell(txReadyFlag_q[0]) && replyBusy[0]
    |-> !charValid_q [*3]) else $error("frame overtook reply");
  chk_pend_rise: assert property ($fell(txReadyFlag_q[0]) |=> unsolPending_q[0])
    else $error("pending not raised");
  // a port reset write may drop a waiting character
  chk_char_hold: assert property (charValid_q && !charReady[charDest_q] && !$past(avs_write
    && !avs_waitrequest && avs_address == `USFS_REG_PORT_RESET)
    |=> charValid_q && $stable(charData_q) && $stable(charDest_q))
    else $error("character not held");
  chk_flag_hold: assert property (!txReadyFlag_q[0] && !portIdle[0]
    |=> !txReadyFlag_q[0] || portReset_q[0]) else $error("flag set early");
  chk_serial_ret: assert property (sCrMain ##1 !portIdle[0] ##1 portIdle[0]
    |=> txReadyFlag_q[0]) else $error("serial flag not restored");
  chk_unit_ret: assert property (sCrTake ##0 charDest_q[1]
    |=> txReadyFlag_q[$past(charDest_q)]) else $error("unit flag not restored");
  chk_reset_pulse: assert property (portReset_q != 4'h0 |-> (txReadyFlag_q & portReset_q)
    == portReset_q ##1 portReset_q == 4'h0) else $error("reset pulse wrong");
  chk_refuse_keep: assert property (avs_write && !avs_waitrequest && avs_address
    == `USFS_REG_SEND_COUNT && avs_writedata[15:0] > 16'h0061
    |=> (txReadyFlag_q & $past(txReadyFlag_q)) == $past(txReadyFlag_q))
    else $error("refused launch cleared a flag");
endmodule // usfs_props
bind usfs_top usfs_props chk (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .charData_q(charData_q), .charValid_q(charValid_q), .charDest_q(charDest_q),
  .charReady(charReady), .portIdle(portIdle), .replyBusy(replyBusy),
  .portReset_q(portReset_q), .unsolPending_q(unsolPending_q), .txReadyFlag_q(txReadyFlag_q));
`default_nettype wire

/* File: usfs_host_model.sv */
// far side: ports and link units taking characters, line busy per char
// assumes the sender's clock; never answers a frame
`timescale 1ns/1ps
`default_nettype none
module usfs_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // character stream
  input wire logic [7:0] charData_q,
  input wire logic charValid_q,
  input wire usfs_pkg::usfs_dest_t charDest_q,
  output logic [3:0] charReady,
  output logic [1:0] portIdle,
  // pacing: stalls acceptance and stretches line time
  input wire logic slow
);
  import usfs_pkg::*;
  logic [9:0] rxq[$];
  logic [2:0] tick;
  always_ff @(posedge ref_clk) tick <= srst ? 3'h0 : tick + 3'h1;
  // takes only, sends nothing back
  assign charReady = (slow && tick[1:0] != 2'h0) ? 4'h0 : 4'hF;
  logic [1:0] busyCnt [2];
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < 2; p++) begin
      if (srst) begin
        busyCnt[p] <= 2'h0;
      end else if (charValid_q && charReady[p] && charDest_q == usfs_dest_t'(p)) begin
        busyCnt[p] <= slow ? 2'h3 : 2'h1;
      end else if (busyCnt[p] != 2'h0) begin
        busyCnt[p] <= busyCnt[p] - 2'h1;
      end
    end
  end
  assign portIdle = {busyCnt[1] == 2'h0, busyCnt[0] == 2'h0};
  always @(posedge ref_clk) begin
    if (!srst && charValid_q && charReady[charDest_q]) rxq.push_back({charDest_q, charData_q});
  end
endmodule // usfs_host_model
`default_nettype wire

/* File: usfs_tb_top.sv */
// self-checking bench for usfs_top against the host model
// assumes usfs_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "usfs_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin badCount++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module usfs_tb_top;
  import usfs_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] avs_address = 14'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] charData_q;
  logic charValid_q;
  usfs_dest_t charDest_q;
  logic [3:0] charReady;
  logic [1:0] portIdle;
  logic [1:0] replyBusy = 2'h0;
  logic [3:0] portReset_q;
  logic [1:0] unsolPending_q;
  logic [3:0] txReadyFlag_q;
  logic slow = 1'b0;
  logic [15:0] mem [256];
  logic [15:0] node [2];
  logic [15:0] rdv;
  int badCount = 0;
  int checked = 0;
  int seed = 32'hB39D61BF;
  usfs_top dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .charData_q(charData_q), .charValid_q(charValid_q),
    .charDest_q(charDest_q), .charReady(charReady), .portIdle(portIdle),
    .replyBusy(replyBusy), .portReset_q(portReset_q), .unsolPending_q(unsolPending_q),
    .txReadyFlag_q(txReadyFlag_q));
  usfs_host_model host (.ref_clk(ref_clk), .srst(srst), .charData_q(charData_q),
    .charValid_q(charValid_q), .charDest_q(charDest_q), .charReady(charReady),
    .portIdle(portIdle), .slow(slow));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("compares %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one Avalon access; waits for the answer rather than assuming its latency
  task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdv = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin badCount++; conclude(); end
  endtask
  task automatic rchk(input logic [13:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    `CHK(rdv, e)
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'hA ? 8'h30 + v : 8'h37 + v;
  endfunction
  task automatic launch(input int d, input int s, input int n);
    bus(1'b1, `USFS_REG_SEND_ADDR, s[15:0]);
    bus(1'b1, `USFS_REG_SEND_CTRL, {2'b00, d[1:0], 12'h000});
    bus(1'b1, `USFS_REG_SEND_COUNT, {8'h00, 4'(n / 10), 4'(n % 10)});
  endtask
  task automatic send(input int d, input int s, input int n, input logic rb);
    logic [7:0] ex[$];
    logic [7:0] fcs;
    logic [15:0] w;
    int t;
    ex = {8'h40, d < 2 ? 8'h30 + node[d][7:4] : 8'h30, d < 2 ? 8'h30 + node[d][3:0] : 8'h30};
    ex.push_back(8'h45);
    ex.push_back(8'h58);
    for (int i = 0; i < n; i++) begin
      w = mem[s + i / 2];
      ex.push_back(hx(i % 2 ? w[7:4] : w[15:12]));
      ex.push_back(hx(i % 2 ? w[3:0] : w[11:8]));
    end
    fcs = 8'h00;
    foreach (ex[i]) fcs ^= ex[i];
    ex = {ex, hx(fcs[7:4]), hx(fcs[3:0]), 8'h2A, 8'h0D};
    host.rxq.delete();
    replyBusy[0] <= rb;
    `CHK(txReadyFlag_q[d], 1'b1)
    launch(d, s, n);
    @(negedge ref_clk);
    `CHK(txReadyFlag_q[d], 1'b0)
    if (rb) begin
      repeat (6) @(posedge ref_clk);
      `CHK(host.rxq.size(), 0)
      `CHK(unsolPending_q, 2'h1)
      replyBusy[0] <= 1'b0;
    end
    t = 0;
    while (txReadyFlag_q[d] !== 1'b1 && t < 3000) begin @(posedge ref_clk); t++; end
    if (t >= 3000) begin badCount++; conclude(); end
    `CHK(host.rxq.size(), ex.size())
    foreach (ex[i]) `CHK(host.rxq[i], {d[1:0], ex[i]})
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'($random(seed));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rchk(`USFS_REG_MAIN_NODE, 16'h0000);
    rchk(`USFS_REG_PERI_NODE, 16'h0000);
    rchk(`USFS_REG_STATUS, 16'h000F);
    rchk(14'h1234, 16'h0000);
    for (int i = 0; i < 256; i++) bus(1'b1, i[13:0], mem[i]);
    bus(1'b1, `USFS_REG_MAIN_NODE, 16'h0031);
    bus(1'b1, `USFS_REG_MAIN_NODE, 16'h0032);
    bus(1'b1, `USFS_REG_MAIN_NODE, 16'h001A);
    bus(1'b1, `USFS_REG_PERI_NODE, 16'h0007);
    rchk(`USFS_REG_MAIN_NODE, 16'h0031);
    avs_byteenable <= 4'h1;
    bus(1'b1, `USFS_REG_PERI_NODE, 16'h0009);
    avs_byteenable <= 4'hF;
    rchk(`USFS_REG_PERI_NODE, 16'h0007);
    node = '{16'h0031, 16'h0007};
    // refused launches: bad counts, bad control code, port out of command-link mode
    foreach (node[i]) begin
      bus(1'b1, `USFS_REG_SEND_CTRL, 16'h0000);
      bus(1'b1, `USFS_REG_SEND_COUNT, i ? 16'h0062 : 16'h001A);
      rchk(`USFS_REG_STATUS, 16'h002F);
    end
    bus(1'b1, `USFS_REG_SEND_CTRL, 16'h4000);
    bus(1'b1, `USFS_REG_SEND_COUNT, 16'h0001);
    rchk(`USFS_REG_STATUS, 16'h002F);
    bus(1'b1, `USFS_REG_MODE, 16'h0002);
    launch(0, 0, 1);
    rchk(`USFS_REG_STATUS, 16'h002F);
    bus(1'b1, `USFS_REG_MODE, 16'h0003);
    send(0, 5, 4, 1'b1);
    for (int k = 0; k < 12; k++) begin
      slow <= k[0];
      send(k % 4, $unsigned($random(seed)) % 200,
           k < 4 ? 61 : k < 8 ? 0 : $unsigned($random(seed)) % 62, 1'b0);
    end
    rchk(`USFS_REG_STATUS, 16'h000F);
    // reset each destination in mid-frame while the far side stalls
    slow <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      launch(d, 0, 61);
      repeat (20) @(posedge ref_clk);
      bus(1'b1, `USFS_REG_PORT_RESET, 16'h1 << d);
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(portReset_q, 4'h1 << d)
      `CHK(txReadyFlag_q[d], 1'b1)
      rchk(`USFS_REG_PORT_RESET, 16'h0000);
    end
    send(1, 40, 3, 1'b0);
    conclude();
  end
endmodule // usfs_tb_top
`default_nettype wire
